// ---- verilog/dacc_regs.svh ----
// register map, field positions and timing counts of the converter control block
// What this block does
// - standby_run clear turns the output buffer off in standby; set keeps it
// - enable write reads back at once; sync busy until it takes effect
// - writing one to soft_reset_request resets all registers and disables
// - a write that sets soft_reset_request discards its other field changes
// - soft_reset_request reads one until reset ends; clears with sync busy
// - reference_select picks internal, analog supply or external reference
// - buffer_protect_bypass exempts the staging buffer from write protection
// - pump_disable clear lets the pump run automatically; set holds it off
// - left_align chooses right or left alignment of data and staging buffer
// - right alignment takes data bits 9:0, left alignment bits 15:6
// - internal_output_enable routes the output to the analog comparator
// - external_output_enable turns on the high-drive output pin buffer
// - converter_config accepts writes only while the converter is disabled
// - empty_event_output set emits buffer-empty events while the buffer is empty
// - start_event_input set lets events load data and start a conversion
// - interrupt_disable write-one clears sync ready, empty, underrun enables
// - interrupt_disable and set registers share and read back one enable set
// - interrupt_set_register write-one sets the matching interrupt enable
// - underrun flag sets on a start event with the staging buffer empty
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH
`define DACC_IDX_MAIN 4'h0
`define DACC_IDX_CFG 4'h1
`define DACC_IDX_EVT 4'h2
`define DACC_IDX_INTDIS 4'h4
`define DACC_IDX_INTSET 4'h5
`define DACC_IDX_FLAGS 4'h6
`define DACC_IDX_STATUS 4'h7
`define DACC_IDX_DATA 4'h8
`define DACC_IDX_STAGE 4'hC
`define DACC_B_SOFT_RESET_REQUEST 0
`define DACC_B_ENABLE 1
`define DACC_B_STDBY 2
`define DACC_B_EXTOUT 0
`define DACC_B_INTOUT 1
`define DACC_B_LEFT 2
`define DACC_B_PUMP 3
`define DACC_B_BYPASS 4
`define DACC_B_REFLO 6
`define DACC_B_REFHI 7
`define DACC_B_START_EVENT_INPUT 0
`define DACC_B_EMPTY_EVENT_OUTPUT 1
`define DACC_B_BUSY 7
`define DACC_F_UNDERRUN 0
`define DACC_F_EMPTY 1
`define DACC_F_SYNC_READY 2
`define DACC_CFG_MASK 8'hDF
`define DACC_EVT_MASK 2'h3
`define DACC_RST_8 8'h00
`define DACC_RST_16 16'h0000
`define DACC_REF_INTERNAL 2'h0
`define DACC_REF_SUPPLY 2'h1
`define DACC_REF_EXTERNAL 2'h2
`define DACC_CLK_MHZ 10
`define DACC_SYNC_NS 400
`define DACC_SYNC_CYC ((`DACC_SYNC_NS * `DACC_CLK_MHZ + 999) / 1000)
`endif

// ---- verilog/dacc_pkg.sv ----
// types shared by the converter control block
package dacc_pkg;
  typedef enum logic [0:0] {SY_IDLE, SY_WAIT} dacc_sync_e;
  typedef logic [2:0] dacc_irq_t;
endpackage

// ---- verilog/dacc_ctrl.sv ----
// converter control registers with wishbone slave, sync tracking and events
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "dacc_regs.svh"
module dacc_ctrl (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic start_event_in,
  input wire logic standby_in,
  input wire logic protect_in,
  output logic conv_enable_out,
  output logic [9:0] conv_sample_out,
  output logic conv_start_out,
  output logic [1:0] ref_sel_out,
  output logic pump_off_out,
  output logic internal_output_out,
  output logic external_output_out,
  output logic empty_event_out,
  output logic irq_out
);
  localparam logic [2:0] SYNC_LOAD = 3'(`DACC_SYNC_CYC);

  // register write allowed by the access controller
  function automatic logic wr_allowed(input logic [3:0] idx, input logic prot,
                                      input logic bypass);
    if (!prot) begin
      wr_allowed = 1'b1;
    end else if (idx == `DACC_IDX_STAGE) begin
      wr_allowed = bypass;
    end else begin
      wr_allowed = 1'b0;
    end
  endfunction

  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic soft_reset_request_r, soft_reset_request_nxt;
  logic enable_r, enable_nxt;
  logic stdby_r, stdby_nxt;
  logic active_r, active_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [1:0] evt_r, evt_nxt;
  dacc_pkg::dacc_irq_t inten_r, inten_nxt;
  dacc_pkg::dacc_irq_t flag_r, flag_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] buf_r, buf_nxt;
  logic buf_full_r, buf_full_nxt;
  logic sw_pend_r, sw_pend_nxt;
  logic en_pend_r, en_pend_nxt;
  logic buf_pend_r, buf_pend_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  dacc_pkg::dacc_sync_e sy_r, sy_nxt;
  logic start_r, start_nxt;
  logic [2:0] ev_sync_r;

  logic [3:0] idx;
  logic wr, busy, sync_done, ev_rise, start_hit;
  dacc_pkg::dacc_irq_t set_v, clr_v;

  assign idx = wb_adr_in[5:2];
  assign busy = sw_pend_r | en_pend_r | buf_pend_r;
  assign wr = wb_cyc_in & wb_stb_in & wb_we_in & ack_r & wb_sel_in[0]
              & wr_allowed(idx, protect_in, cfg_r[`DACC_B_BYPASS]);
  assign sync_done = (sy_r == dacc_pkg::SY_WAIT) && (cnt_r == 3'h1);
  assign ev_rise = ev_sync_r[1] & ~ev_sync_r[2];
  assign start_hit = ev_rise & evt_r[`DACC_B_START_EVENT_INPUT] & active_r;

  // two-flop synchroniser plus edge history for the start event
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_sync_r <= 3'h0;
    end else if (ce_in) begin
      ev_sync_r <= {ev_sync_r[1:0], start_event_in};
    end
  end

  always_comb begin
    ack_nxt = wb_cyc_in & wb_stb_in & ~ack_r;
    rd_nxt = 32'h0000_0000;
    case (idx)
      `DACC_IDX_MAIN: rd_nxt[2:0] = {stdby_r, enable_r, soft_reset_request_r};
      `DACC_IDX_CFG: rd_nxt[7:0] = cfg_r;
      `DACC_IDX_EVT: rd_nxt[1:0] = evt_r;
      `DACC_IDX_INTDIS: rd_nxt[2:0] = inten_r;
      `DACC_IDX_INTSET: rd_nxt[2:0] = inten_r;
      `DACC_IDX_FLAGS: rd_nxt[2:0] = flag_r;
      `DACC_IDX_STATUS: rd_nxt[`DACC_B_BUSY] = busy;
      default: rd_nxt = 32'h0000_0000;
    endcase
    if (!ack_nxt) begin
      rd_nxt = rd_r;
    end
  end

  always_comb begin
    soft_reset_request_nxt = soft_reset_request_r;
    enable_nxt = enable_r;
    stdby_nxt = stdby_r;
    active_nxt = active_r;
    cfg_nxt = cfg_r;
    evt_nxt = evt_r;
    inten_nxt = inten_r;
    data_nxt = data_r;
    buf_nxt = buf_r;
    buf_full_nxt = buf_full_r;
    sw_pend_nxt = sw_pend_r;
    en_pend_nxt = en_pend_r;
    buf_pend_nxt = buf_pend_r;
    cnt_nxt = cnt_r;
    sy_nxt = sy_r;
    start_nxt = 1'b0;
    set_v = 3'h0;
    clr_v = 3'h0;
    case (sy_r)
      dacc_pkg::SY_IDLE: begin
        cnt_nxt = 3'h0;
      end
      dacc_pkg::SY_WAIT: begin
        cnt_nxt = cnt_r - 3'h1;
        if (sync_done) begin
          sy_nxt = dacc_pkg::SY_IDLE;
          set_v[`DACC_F_SYNC_READY] = 1'b1;
          en_pend_nxt = 1'b0;
          buf_pend_nxt = 1'b0;
          if (en_pend_r) begin
            active_nxt = enable_r;
          end
          if (buf_pend_r) begin
            buf_full_nxt = 1'b1;
          end
        end
      end
      default: begin
        sy_nxt = dacc_pkg::SY_IDLE;
      end
    endcase
    if (start_hit) begin
      if (buf_full_r) begin
        data_nxt = buf_r;
        buf_full_nxt = 1'b0;
        start_nxt = 1'b1;
        set_v[`DACC_F_EMPTY] = 1'b1;
      end else begin
        set_v[`DACC_F_UNDERRUN] = 1'b1;
      end
    end
    if (wr) begin
      case (idx)
        `DACC_IDX_MAIN: begin
          if (wb_dat_in[`DACC_B_SOFT_RESET_REQUEST]) begin
            if (!busy) begin
              soft_reset_request_nxt = 1'b1;
              sw_pend_nxt = 1'b1;
              sy_nxt = dacc_pkg::SY_WAIT;
              cnt_nxt = SYNC_LOAD;
            end
          end else begin
            stdby_nxt = wb_dat_in[`DACC_B_STDBY];
            if (!busy) begin
              enable_nxt = wb_dat_in[`DACC_B_ENABLE];
              en_pend_nxt = 1'b1;
              sy_nxt = dacc_pkg::SY_WAIT;
              cnt_nxt = SYNC_LOAD;
            end
          end
        end
        `DACC_IDX_CFG: begin
          if (!enable_r && !active_r) begin
            cfg_nxt = wb_dat_in[7:0] & `DACC_CFG_MASK;
          end
        end
        `DACC_IDX_EVT: evt_nxt = wb_dat_in[1:0] & `DACC_EVT_MASK;
        `DACC_IDX_INTDIS: inten_nxt = inten_r & ~wb_dat_in[2:0];
        `DACC_IDX_INTSET: inten_nxt = inten_r | wb_dat_in[2:0];
        `DACC_IDX_FLAGS: clr_v = wb_dat_in[2:0];
        `DACC_IDX_DATA: begin
          if (wb_sel_in[1]) begin
            data_nxt = wb_dat_in[15:0];
          end
        end
        `DACC_IDX_STAGE: begin
          if (wb_sel_in[1] && !busy) begin
            buf_nxt = wb_dat_in[15:0];
            buf_full_nxt = 1'b0;
            buf_pend_nxt = 1'b1;
            sy_nxt = dacc_pkg::SY_WAIT;
            cnt_nxt = SYNC_LOAD;
            clr_v[`DACC_F_EMPTY] = 1'b1;
          end
        end
        default: begin
          clr_v = 3'h0;
        end
      endcase
    end
    for (int i = 0; i < 3; i++) begin
      flag_nxt[i] = set_v[i] | (flag_r[i] & ~clr_v[i]);
    end
    if (sync_done && sw_pend_r) begin
      soft_reset_request_nxt = 1'b0;
      sw_pend_nxt = 1'b0;
      enable_nxt = 1'b0;
      active_nxt = 1'b0;
      stdby_nxt = 1'b0;
      cfg_nxt = `DACC_RST_8;
      evt_nxt = 2'h0;
      inten_nxt = 3'h0;
      flag_nxt = 3'h0;
      data_nxt = `DACC_RST_16;
      buf_nxt = `DACC_RST_16;
      buf_full_nxt = 1'b0;
      en_pend_nxt = 1'b0;
      buf_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      soft_reset_request_r <= 1'b0;
      enable_r <= 1'b0;
      stdby_r <= 1'b0;
      active_r <= 1'b0;
      cfg_r <= `DACC_RST_8;
      evt_r <= 2'h0;
      inten_r <= 3'h0;
      flag_r <= 3'h0;
      data_r <= `DACC_RST_16;
      buf_r <= `DACC_RST_16;
      buf_full_r <= 1'b0;
      sw_pend_r <= 1'b0;
      en_pend_r <= 1'b0;
      buf_pend_r <= 1'b0;
      cnt_r <= 3'h0;
      sy_r <= dacc_pkg::SY_IDLE;
      start_r <= 1'b0;
    end else if (ce_in) begin
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      soft_reset_request_r <= soft_reset_request_nxt;
      enable_r <= enable_nxt;
      stdby_r <= stdby_nxt;
      active_r <= active_nxt;
      cfg_r <= cfg_nxt;
      evt_r <= evt_nxt;
      inten_r <= inten_nxt;
      flag_r <= flag_nxt;
      data_r <= data_nxt;
      buf_r <= buf_nxt;
      buf_full_r <= buf_full_nxt;
      sw_pend_r <= sw_pend_nxt;
      en_pend_r <= en_pend_nxt;
      buf_pend_r <= buf_pend_nxt;
      cnt_r <= cnt_nxt;
      sy_r <= sy_nxt;
      start_r <= start_nxt;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rd_r;
  assign conv_enable_out = active_r;
  assign conv_start_out = start_r;
  assign conv_sample_out = cfg_r[`DACC_B_LEFT] ? data_r[15:6] : data_r[9:0];
  assign ref_sel_out = cfg_r[`DACC_B_REFHI:`DACC_B_REFLO];
  assign pump_off_out = cfg_r[`DACC_B_PUMP];
  assign internal_output_out = cfg_r[`DACC_B_INTOUT] & active_r;
  assign external_output_out = cfg_r[`DACC_B_EXTOUT] & active_r
                               & ~(standby_in & ~stdby_r);
  assign empty_event_out = evt_r[`DACC_B_EMPTY_EVENT_OUTPUT] & active_r & ~buf_full_r;
  assign irq_out = |(flag_r & inten_r);

  a_soft_reset_request_readback: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && wr && idx == `DACC_IDX_MAIN && wb_dat_in[`DACC_B_SOFT_RESET_REQUEST] && !busy)
      |=> soft_reset_request_r && busy)
    else $error("soft reset not pending after write");
  a_soft_reset_request_discard: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && wr && idx == `DACC_IDX_MAIN && wb_dat_in[`DACC_B_SOFT_RESET_REQUEST]
      && !(sync_done && sw_pend_r)) |=> $stable(enable_r))
    else $error("soft reset write changed enable");
  a_soft_reset_request_done: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && sync_done && sw_pend_r) |=> !enable_r && !soft_reset_request_r && !busy && cfg_r == `DACC_RST_8)
    else $error("soft reset did not restore registers");
  a_enable_sync: assert property (@(posedge clk_sys_in) disable iff (!rstn_in || !ce_in)
    $rose(en_pend_r) |-> ##[1:8] (!en_pend_r && active_r == enable_r))
    else $error("enable did not take effect in time");
  a_cfg_locked: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (enable_r && active_r && !sw_pend_r) |=> $stable(cfg_r))
    else $error("config changed while enabled");
  a_underrun_irq: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && start_hit && !buf_full_r && !sw_pend_r)
      |=> flag_r[`DACC_F_UNDERRUN] && (irq_out || !inten_r[`DACC_F_UNDERRUN]))
    else $error("underrun not flagged");
  a_left_sample: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && start_hit && buf_full_r && cfg_r[`DACC_B_LEFT] && !sync_done)
      |=> conv_sample_out == $past(buf_r[15:6]) && conv_start_out)
    else $error("left aligned sample wrong");
  a_intdis_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ce_in && wr && idx == `DACC_IDX_INTDIS && !(sync_done && sw_pend_r))
      |=> (inten_r & $past(wb_dat_in[2:0])) == 3'h0)
    else $error("interrupt enable not cleared");
endmodule // dacc_ctrl

// ---- test/dacc_evsrc.sv ----
// event channel model that drives the start event line
`timescale 1ns/100ps
module dacc_evsrc (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic fire_in,
  output logic start_event_out
);
  logic [1:0] cnt_r;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 2'h0;
    end else if (fire_in) begin
      cnt_r <= 2'h3;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end
  // held high three cycles so the two-flop synchroniser sees it
  assign start_event_out = (cnt_r != 2'h0);
endmodule // dacc_evsrc

// ---- test/dacc_ctrl_test.sv ----
// self-checking bench for the converter control block
`timescale 1ns/100ps
`include "dacc_regs.svh"
module dacc_ctrl_test;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic stby = 1'b0;
  logic prot = 1'b0;
  logic fire = 1'b0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, sev, en, cst, poff, io, eo, ee, irq, seen;
  logic [9:0] smp;
  logic [1:0] rsel;
  int fails = 0;
  int checked = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  dacc_evsrc dacc_evsrc_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .fire_in(fire),
    .start_event_out(sev));
  dacc_ctrl dacc_ctrl_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .start_event_in(sev),
    .standby_in(stby), .protect_in(prot), .conv_enable_out(en), .conv_sample_out(smp),
    .conv_start_out(cst), .ref_sel_out(rsel), .pump_off_out(poff),
    .internal_output_out(io), .external_output_out(eo), .empty_event_out(ee),
    .irq_out(irq));
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    n = 0;
    @(posedge clk_sys_in);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        end_sim();
      end
      @(posedge clk_sys_in);
    end
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rdc(input string nm, input logic [3:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic idle();
    int n;
    n = 0;
    rd = 32'h80;
    while (rd[7] !== 1'b0) begin
      n++;
      if (n > 20) begin
        fails++;
        end_sim();
      end
      wb(1'b0, `DACC_IDX_STATUS, 32'h0);
    end
  endtask
  task automatic fire_ev();
    fire <= 1'b1;
    @(posedge clk_sys_in);
    fire <= 1'b0;
    seen = 1'b0;
    repeat (10) begin
      @(negedge clk_sys_in);
      if (cst === 1'b1) begin
        seen = 1'b1;
      end
    end
    @(posedge clk_sys_in);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    rdc("main", `DACC_IDX_MAIN, 32'h0);
    rdc("cfg", `DACC_IDX_CFG, 32'h0);
    rdc("evt", `DACC_IDX_EVT, 32'h0);
    rdc("intdis", `DACC_IDX_INTDIS, 32'h0);
    rdc("unmapped", 4'h3, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      wb(1'b1, `DACC_IDX_CFG, {24'h0, r[1:0], 6'h00});
      chk("ref_sel", r, {30'h0, rsel});
    end
    wb(1'b1, `DACC_IDX_CFG, 32'hFF);
    rdc("cfg", `DACC_IDX_CFG, 32'hDF);
    chk("pump_off", 32'h1, {31'h0, poff});
    wb(1'b1, `DACC_IDX_CFG, 32'h1F);
    wb(1'b1, `DACC_IDX_MAIN, 32'h2);
    chk("enable_early", 32'h0, {31'h0, en});
    rdc("main", `DACC_IDX_MAIN, 32'h2);
    idle();
    chk("enable", 32'h1, {31'h0, en});
    chk("int_out", 32'h1, {31'h0, io});
    chk("ext_out", 32'h1, {31'h0, eo});
    stby <= 1'b1;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    chk("ext_stby", 32'h0, {31'h0, eo});
    wb(1'b1, `DACC_IDX_MAIN, 32'h6);
    chk("ext_run", 32'h1, {31'h0, eo});
    stby <= 1'b0;
    wb(1'b1, `DACC_IDX_CFG, 32'h0);
    rdc("cfg_locked", `DACC_IDX_CFG, 32'h1F);
    $display("test enable done");
    wb(1'b1, `DACC_IDX_INTSET, 32'h7);
    rdc("intdis", `DACC_IDX_INTDIS, 32'h7);
    wb(1'b1, `DACC_IDX_INTDIS, 32'h1);
    rdc("intset", `DACC_IDX_INTSET, 32'h6);
    wb(1'b1, `DACC_IDX_INTDIS, 32'h0);
    rdc("intset", `DACC_IDX_INTSET, 32'h6);
    wb(1'b1, `DACC_IDX_FLAGS, 32'h7);
    wb(1'b1, `DACC_IDX_EVT, 32'h1);
    wb(1'b1, `DACC_IDX_STAGE, 32'hABC0);
    idle();
    rdc("flags_sync", `DACC_IDX_FLAGS, 32'h4);
    fire_ev();
    chk("start", 32'h1, {31'h0, seen});
    chk("sample", 32'h2AF, {22'h0, smp});
    rdc("flags", `DACC_IDX_FLAGS, 32'h6);
    chk("irq_on", 32'h1, {31'h0, irq});
    wb(1'b1, `DACC_IDX_FLAGS, 32'h7);
    chk("irq_off", 32'h0, {31'h0, irq});
    wb(1'b1, `DACC_IDX_EVT, 32'h3);
    chk("empty_ev", 32'h1, {31'h0, ee});
    fire_ev();
    rdc("underrun", `DACC_IDX_FLAGS, 32'h1);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wb(1'b1, `DACC_IDX_INTSET, 32'h1);
    chk("irq_under", 32'h1, {31'h0, irq});
    wb(1'b1, `DACC_IDX_FLAGS, 32'h7);
    wb(1'b1, `DACC_IDX_EVT, 32'h0);
    chk("empty_off", 32'h0, {31'h0, ee});
    fire_ev();
    chk("no_start", 32'h0, {31'h0, seen});
    rdc("flags_off", `DACC_IDX_FLAGS, 32'h0);
    $display("test events done");
    prot <= 1'b1;
    wb(1'b1, `DACC_IDX_EVT, 32'h1);
    rdc("evt_prot", `DACC_IDX_EVT, 32'h0);
    wb(1'b1, `DACC_IDX_STAGE, 32'h0040);
    idle();
    rdc("stage_byp", `DACC_IDX_FLAGS, 32'h4);
    prot <= 1'b0;
    wb(1'b1, `DACC_IDX_MAIN, 32'h1);
    rdc("soft_reset_request_on", `DACC_IDX_MAIN, 32'h7);
    idle();
    rdc("main_rst", `DACC_IDX_MAIN, 32'h0);
    rdc("cfg_rst", `DACC_IDX_CFG, 32'h0);
    rdc("intset_rst", `DACC_IDX_INTSET, 32'h0);
    chk("disabled", 32'h0, {31'h0, en});
    wb(1'b1, `DACC_IDX_DATA, 32'hABC0);
    chk("sample_right", 32'h3C0, {22'h0, smp});
    wb(1'b1, `DACC_IDX_CFG, 32'h4);
    chk("sample_left", 32'h2AF, {22'h0, smp});
    $display("test soft reset done");
    end_sim();
  end
endmodule // dacc_ctrl_test
